// file: maint_hours_counter.sv
// maintenance hours counter: accrued time, time left to service, due output
//
// Strobed register access and the address map are this design's own decisions.
`include "mhc_defines.svh"

module maint_hours_counter #(
    parameter logic [35:0] MINUTE_CYCLES = 36'(`MINUTE_NS / `CLK_PERIOD_NS)
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        backup_clr_in,
    // plant pins
    input  wire logic        monitor_in,
    input  wire logic        kick_in,
    input  wire logic        wipe_all_in,
    // live value of another function
    input  wire logic [15:0] ext_span_in,
    // register port
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // results
    output logic             due_out,
    output logic             irq_out
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic mhc_pkg::span_time_t clamp_span(input logic [16:0] h, input logic [5:0] m);
        mhc_pkg::span_time_t s;
        s.hours = (h > 17'(`SPAN_MAX_HOURS)) ? `SPAN_MAX_HOURS : h[13:0];
        s.mins  = (m > `MIN_LAST) ? `MIN_LAST : m;
        return s;
    endfunction : clamp_span

    function automatic logic [22:0] to_minutes(input logic [16:0] h, input logic [5:0] m);
        return 23'(h) * 23'(`MINS_PER_HOUR) + 23'(m);
    endfunction : to_minutes

    // ----------------------------------------------------------------
    // pins and time base
    // ----------------------------------------------------------------
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic       min_tick;

    pin_sync_edge #(.W(3)) u_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     ({wipe_all_in, kick_in, monitor_in}),
        .level_out  (pin_lvl),
        .rise_out   (pin_rise)
    );

    minute_tick #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_tick (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .tick_out   (min_tick)
    );

    logic mon_lvl;
    logic kick_lvl;
    logic wipe_lvl;
    logic kick_rise;
    logic wipe_rise;
    logic count_en;

    assign mon_lvl   = pin_lvl[`PIN_MON];
    assign kick_lvl  = pin_lvl[`PIN_KICK];
    assign wipe_lvl  = pin_lvl[`PIN_WIPE];
    assign kick_rise = pin_rise[`PIN_KICK];
    assign wipe_rise = pin_rise[`PIN_WIPE];
    assign count_en  = min_tick & mon_lvl;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    mhc_pkg::due_mode_t due_mode_r;
    mhc_pkg::span_src_t span_src_r;
    logic               run_r;
    logic               ctrl_wr;
    logic               span_wr;
    logic               preset_wr;
    logic               stat_rd;

    assign ctrl_wr   = reg_wr_in && (reg_addr_in == `REG_CTRL);
    assign span_wr   = reg_wr_in && (reg_addr_in == `REG_SPAN);
    assign preset_wr = reg_wr_in && (reg_addr_in == `REG_HOURS_PRESET) && !run_r;
    assign stat_rd   = reg_rd_in && (reg_addr_in == `REG_IRQ_STAT);

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            due_mode_r <= mhc_pkg::KICK_CLEARS;
            span_src_r <= mhc_pkg::SPAN_FIXED;
            run_r      <= 1'b0;
        end else if (ctrl_wr) begin
            due_mode_r <= mhc_pkg::due_mode_t'(reg_wdata_in[`CTRL_MODE_BIT]);
            span_src_r <= mhc_pkg::span_src_t'(reg_wdata_in[`CTRL_SRC_BIT]);
            run_r      <= reg_wdata_in[`CTRL_RUN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // service span (retained, cleared only on backup loss)
    // ----------------------------------------------------------------
    mhc_pkg::span_time_t span_r;
    mhc_pkg::span_time_t span_last_r;
    mhc_pkg::span_time_t span_cur;
    logic                span_chg;

    always_ff @(posedge mclk_in) begin
        if (backup_clr_in) begin
            span_r <= '0;
        end else if (span_wr) begin
            span_r <= clamp_span(17'(reg_wdata_in[15:0]), reg_wdata_in[`MINS_FIELD_LSB +: 6]);
        end
    end

    always_comb begin
        if (span_src_r == mhc_pkg::SPAN_LIVE) begin
            span_cur = clamp_span(17'(ext_span_in), 6'h0);
        end else begin
            span_cur = span_r;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (backup_clr_in) begin
            span_last_r <= '0;
        end else begin
            span_last_r <= span_cur;
        end
    end

    assign span_chg = (span_cur != span_last_r);

    // ----------------------------------------------------------------
    // hours preset arithmetic
    // ----------------------------------------------------------------
    mhc_pkg::accrued_time_t preset_val;
    mhc_pkg::span_time_t    preset_left;
    logic [22:0]            span_min;
    logic [22:0]            acc_min;
    logic [22:0]            left_min;

    always_comb begin
        preset_val.hours = (reg_wdata_in[16:0] > `HOURS_LIMIT) ? `HOURS_LIMIT : reg_wdata_in[16:0];
        preset_val.mins  = (reg_wdata_in[`MINS_FIELD_LSB +: 6] > `MIN_LAST) ? `MIN_LAST
                                                                             : reg_wdata_in[`MINS_FIELD_LSB +: 6];
        span_min = to_minutes(17'(span_cur.hours), span_cur.mins);
        acc_min  = to_minutes(preset_val.hours, preset_val.mins);
        left_min = (span_min == 23'h0) ? 23'h0 : span_min - (acc_min % span_min);
        preset_left.hours = 14'(left_min / 23'(`MINS_PER_HOUR));
        preset_left.mins  = 6'(left_min % 23'(`MINS_PER_HOUR));
    end

    // ----------------------------------------------------------------
    // time left (retained)
    // ----------------------------------------------------------------
    mhc_pkg::span_time_t time_left_r;
    logic                left_zero;

    assign left_zero = (time_left_r == '0);

    always_ff @(posedge mclk_in) begin
        if (backup_clr_in) begin
            time_left_r <= '0;
        end else if (kick_rise || wipe_rise) begin
            time_left_r <= span_cur;
        end else if (span_chg) begin
            time_left_r <= span_cur;
        end else if (preset_wr) begin
            time_left_r <= preset_left;
        end else if (count_en && !left_zero) begin
            if (time_left_r.mins == 6'h0) begin
                time_left_r.hours <= time_left_r.hours - 14'h1;
                time_left_r.mins  <= `MIN_LAST;
            end else begin
                time_left_r.mins  <= time_left_r.mins - 6'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // accrued hours (retained)
    // ----------------------------------------------------------------
    mhc_pkg::accrued_time_t accrued_r;
    logic                   acc_sat;

    assign acc_sat = (accrued_r.hours == `HOURS_LIMIT);

    always_ff @(posedge mclk_in) begin
        if (backup_clr_in) begin
            accrued_r <= '0;
        end else if (wipe_rise) begin
            accrued_r <= '0;
        end else if (preset_wr) begin
            accrued_r <= preset_val;
        end else if (count_en && !acc_sat) begin
            if (accrued_r.mins == `MIN_LAST) begin
                accrued_r.hours <= accrued_r.hours + 17'h1;
                accrued_r.mins  <= 6'h0;
            end else begin
                accrued_r.mins  <= accrued_r.mins + 6'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // due output
    // ----------------------------------------------------------------
    logic due_r;
    logic due_clr;
    logic due_nxt;

    assign due_clr = kick_lvl || wipe_lvl || ((due_mode_r == mhc_pkg::IDLE_CLEARS) && !mon_lvl);
    assign due_nxt = !due_clr && left_zero;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            due_r <= 1'b0;
        end else begin
            due_r <= due_nxt;
        end
    end

    assign due_out = due_r;

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic [`IRQ_WIDTH-1:0] irq_stat_r;
    logic [`IRQ_WIDTH-1:0] irq_mask_r;
    logic [`IRQ_WIDTH-1:0] irq_evt;

    always_comb begin
        irq_evt                = '0;
        irq_evt[`IRQ_DUE_BIT]  = due_nxt && !due_r;
        irq_evt[`IRQ_KICK_BIT] = kick_rise;
        irq_evt[`IRQ_WIPE_BIT] = wipe_rise;
        irq_evt[`IRQ_SAT_BIT]  = count_en && !acc_sat && (accrued_r.hours == `HOURS_LIMIT - 17'h1)
                                 && (accrued_r.mins == `MIN_LAST);
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            irq_stat_r <= '0;
        end else if (stat_rd) begin
            irq_stat_r <= irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            irq_mask_r <= `IRQ_MASK_RST;
        end else if (reg_wr_in && (reg_addr_in == `REG_IRQ_MASK)) begin
            irq_mask_r <= reg_wdata_in[`IRQ_WIDTH-1:0];
        end
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    always_comb begin
        rdata_nxt = '0;
        unique case (reg_addr_in)
            `REG_CTRL: begin
                rdata_nxt[`CTRL_MODE_BIT] = due_mode_r;
                rdata_nxt[`CTRL_SRC_BIT]  = span_src_r;
                rdata_nxt[`CTRL_RUN_BIT]  = run_r;
            end
            `REG_SPAN: begin
                rdata_nxt[13:0]                  = span_cur.hours;
                rdata_nxt[`MINS_FIELD_LSB +: 6]  = span_cur.mins;
            end
            `REG_TIME_LEFT: begin
                rdata_nxt[13:0]                  = time_left_r.hours;
                rdata_nxt[`MINS_FIELD_LSB +: 6]  = time_left_r.mins;
            end
            `REG_HOURS: begin
                rdata_nxt[16:0]                  = accrued_r.hours;
                rdata_nxt[`MINS_FIELD_LSB +: 6]  = accrued_r.mins;
            end
            `REG_STATUS: begin
                rdata_nxt[0] = due_r;
                rdata_nxt[1] = mon_lvl;
                rdata_nxt[2] = acc_sat;
            end
            `REG_IRQ_STAT: rdata_nxt[`IRQ_WIDTH-1:0] = irq_stat_r;
            `REG_IRQ_MASK: rdata_nxt[`IRQ_WIDTH-1:0] = irq_mask_r;
            default:       rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rdata_r <= '0;
        end else if (reg_rd_in) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign reg_rdata_out = rdata_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in || backup_clr_in);

    chk_kick_reload: assert property (kick_rise |=> time_left_r == $past(span_cur))
        else $error("kick did not reload time left");
    chk_wipe_zero: assert property (wipe_rise |=> accrued_r == '0 && time_left_r == $past(span_cur))
        else $error("wipe-all did not zero hours or reload time left");
    chk_idle_freeze: assert property (!mon_lvl && !wipe_rise && !preset_wr |=> $stable(accrued_r))
        else $error("hours moved while monitored input low");
    chk_due_set: assert property (left_zero && !due_clr |=> due_out)
        else $error("due not raised at zero time left");
    chk_kick_low: assert property (kick_lvl || wipe_lvl |=> !due_out)
        else $error("due high while kick or wipe-all high");
    chk_idle_low: assert property (due_mode_r == mhc_pkg::IDLE_CLEARS && !mon_lvl |=> !due_out)
        else $error("due high while idle in idle-clears mode");
    chk_kick_count: assert property (count_en && kick_lvl && !acc_sat && !wipe_rise && !preset_wr
                                     |=> accrued_r != $past(accrued_r))
        else $error("hours stalled while kick high");
    chk_hours_sat: assert property (acc_sat && !wipe_rise && !preset_wr |=> acc_sat)
        else $error("accrued hours left the limit");
    chk_span_range: assert property (span_cur.hours <= `SPAN_MAX_HOURS && span_cur.mins <= `MIN_LAST)
        else $error("span out of range");
    chk_preset_left: assert property (preset_wr && !kick_rise && !wipe_rise && !span_chg
                                      |=> time_left_r == $past(preset_left))
        else $error("preset did not set time left");
    chk_span_load: assert property (span_chg && !kick_rise && !wipe_rise |=> time_left_r == $past(span_cur))
        else $error("span change did not load time left");
    chk_zero_hold: assert property (left_zero && !kick_rise && !wipe_rise && !span_chg && !preset_wr
                                    |=> left_zero)
        else $error("time left moved off zero");
    chk_minute_step: assert property (count_en && time_left_r.mins != 6'h0 && !kick_rise && !wipe_rise
                                      && !span_chg && !preset_wr
                                      |=> time_left_r.mins == $past(time_left_r.mins) - 6'h1)
        else $error("time left not one minute down");

    cov_due_raised: cover property (!due_out ##1 due_out);
    cov_kick_clear: cover property (due_out ##1 kick_rise ##1 !due_out);
    cov_wipe_all:   cover property (wipe_rise && accrued_r != '0);
    cov_irq_fire:   cover property (!irq_out ##1 irq_out);

endmodule : maint_hours_counter

// file: mhc_defines.svh
// offsets, field positions, limits and timing constants of the maintenance hours counter
`ifndef MHC_DEFINES_SVH
`define MHC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL         5'h00
`define REG_SPAN         5'h04
`define REG_HOURS_PRESET 5'h08
`define REG_TIME_LEFT    5'h0c
`define REG_HOURS        5'h10
`define REG_STATUS       5'h14
`define REG_IRQ_STAT     5'h18
`define REG_IRQ_MASK     5'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_MODE_BIT    0
`define CTRL_SRC_BIT     1
`define CTRL_RUN_BIT     2
`define HOURS_FIELD_LSB  0
`define MINS_FIELD_LSB   24
`define IRQ_DUE_BIT      0
`define IRQ_KICK_BIT     1
`define IRQ_WIPE_BIT     2
`define IRQ_SAT_BIT      3
`define IRQ_WIDTH        4
`define PIN_MON          0
`define PIN_KICK         1
`define PIN_WIPE         2

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define IRQ_MASK_RST     4'h0
`define HOURS_LIMIT      17'h1869f
`define SPAN_MAX_HOURS   14'h270f
`define MIN_LAST         6'h3b
`define MINS_PER_HOUR    6'h3c

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MINUTE_NS        36'hdf8475800
`define CLK_PERIOD_NS    36'h4

`endif

// file: mhc_pkg.sv
// types shared by the maintenance hours counter files
package mhc_pkg;

    typedef struct packed {
        logic [13:0] hours;
        logic [5:0]  mins;
    } span_time_t;

    typedef struct packed {
        logic [16:0] hours;
        logic [5:0]  mins;
    } accrued_time_t;

    typedef enum logic {
        KICK_CLEARS,
        IDLE_CLEARS
    } due_mode_t;

    typedef enum logic {
        SPAN_FIXED,
        SPAN_LIVE
    } span_src_t;

endpackage : mhc_pkg

// file: minute_tick.sv
// one-cycle pulse once per minute of mclk_in
module minute_tick #(
    parameter logic [35:0] MINUTE_CYCLES = 36'h37e11d600
) (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    // time base
    output logic      tick_out
);

    logic [35:0] cnt_r;
    logic        tick_r;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r >= MINUTE_CYCLES - 36'h1) begin
            cnt_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 36'h1;
            tick_r <= 1'b0;
        end
    end

    assign tick_out = tick_r;

endmodule : minute_tick

// file: pin_sync_edge.sv
// two-flop synchronisers with rising-edge detect for plant pins
module pin_sync_edge #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         sys_rst_in,
    // raw pins
    input  wire logic [W-1:0] pin_in,
    // synchronised level and edge
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            meta_r   <= '0;
            stable_r <= '0;
            prev_r   <= '0;
        end else begin
            meta_r   <= pin_in;
            stable_r <= meta_r;
            prev_r   <= stable_r;
        end
    end

    assign level_out = stable_r;
    assign rise_out  = stable_r & ~prev_r;

endmodule : pin_sync_edge

// file: plant_model.sv
// plant side: monitored, kick and wipe-all pins plus live span of another function
module plant_model (
    // clock
    input  wire logic        mclk_in,
    // requested levels: bit0 monitor, bit1 kick, bit2 wipe-all
    input  wire logic [2:0]  pins_in,
    input  wire logic [15:0] span_in,
    // plant pins
    output logic             monitor_out,
    output logic             kick_out,
    output logic             wipe_out,
    output logic      [15:0] ext_span_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins change only just after an edge, like circuit logic
    always_ff @(posedge mclk_in) begin
        monitor_out  <= pins_in[0];
        kick_out     <= pins_in[1];
        wipe_out     <= pins_in[2];
        ext_span_out <= span_in;
    end
endmodule : plant_model

// file: tb_top.sv
// self-checking bench for the maintenance hours counter
`include "mhc_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------
    // signals
    // --------------------
    logic        mclk_in;
    logic        sys_rst_in;
    logic        backup_clr_in;
    logic [2:0]  pins;
    logic [15:0] espan;
    logic        monitor;
    logic        kick;
    logic        wipe;
    logic [15:0] ext_span;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] reg_rdata_out;
    logic        due_out;
    logic        irq_out;
    logic [31:0] v;
    logic [31:0] hk;
    int          miscompares;
    int          checks_done;

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    plant_model i_plant (.mclk_in(mclk_in), .pins_in(pins), .span_in(espan), .monitor_out(monitor),
        .kick_out(kick), .wipe_out(wipe), .ext_span_out(ext_span));

    maint_hours_counter #(.MINUTE_CYCLES(36'h10)) i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .backup_clr_in(backup_clr_in), .monitor_in(monitor), .kick_in(kick), .wipe_all_in(wipe),
        .ext_span_in(ext_span), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_stb),
        .reg_rd_in(rd_stb), .reg_rdata_out(reg_rdata_out), .due_out(due_out), .irq_out(irq_out));

    // --------------------
    // tasks
    // --------------------
    function automatic logic [31:0] tv(input logic [16:0] h, input logic [5:0] m);
        return {2'h0, m, 7'h00, h};
    endfunction : tv

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk_in);
        wr_stb <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk_in);
        rd_stb <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : rd_reg

    task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string what);
        logic [31:0] d;
        rd_reg(a, d);
        check(what, d, e);
    endtask : rchk

    task automatic wait_due(input logic lvl);
        int n;
        n = 0;
        while (due_out !== lvl && n < 400) begin
            @(posedge mclk_in);
            n++;
        end
        check("due_out", {31'h0, due_out}, {31'h0, lvl});
        if (n >= 400) begin
            final_report();
        end
    endtask : wait_due

    task automatic poll_hours(input logic [31:0] old, output logic [31:0] d);
        int n;
        n = 0;
        d = old;
        while (d === old && n < 100) begin
            rd_reg(`REG_HOURS, d);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            final_report();
        end
    endtask : poll_hours

    // --------------------
    // sequence
    // --------------------
    initial begin
        sys_rst_in    = 1'b1;
        backup_clr_in = 1'b1;
        pins          = 3'h0;
        espan         = 16'h0000;
        addr          = 5'h00;
        wdata         = 32'h0;
        wr_stb        = 1'b0;
        rd_stb        = 1'b0;
        miscompares   = 0;
        checks_done   = 0;
        repeat (16) @(posedge mclk_in);
        sys_rst_in    <= 1'b0;
        backup_clr_in <= 1'b0;
        rchk(`REG_CTRL, 32'h0, "ctrl");
        rchk(`REG_IRQ_MASK, 32'h0, "irq_mask");
        rchk(5'h1e, 32'h0, "unmapped");
        wr_reg(`REG_SPAN, 32'h3f00ffff);
        rchk(`REG_SPAN, tv(17'h0270f, 6'h3b), "span_clamp");
        wr_reg(`REG_SPAN, tv(17'h0001e, 6'h00));
        rchk(`REG_TIME_LEFT, tv(17'h0001e, 6'h00), "left_load");
        wr_reg(`REG_HOURS_PRESET, tv(17'h00064, 6'h00));
        rchk(`REG_TIME_LEFT, tv(17'h00014, 6'h00), "left_preset_h");
        wr_reg(`REG_SPAN, tv(17'h0, 6'h03));
        wr_reg(`REG_HOURS_PRESET, tv(17'h0, 6'h0a));
        rchk(`REG_TIME_LEFT, tv(17'h0, 6'h02), "left_preset_m");
        wr_reg(`REG_IRQ_MASK, 32'h1);
        wr_reg(`REG_CTRL, 32'h4);
        pins <= 3'h1;
        wait_due(1'b1);
        repeat (40) @(posedge mclk_in);
        rchk(`REG_TIME_LEFT, 32'h0, "left_zero");
        check("irq_due", {31'h0, irq_out}, 32'h1);
        rchk(`REG_IRQ_STAT, 32'h1, "irq_stat");
        check("irq_clear", {31'h0, irq_out}, 32'h0);
        pins <= 3'h0;
        repeat (8) @(posedge mclk_in);
        check("due_kick_mode", {31'h0, due_out}, 32'h1);
        rd_reg(`REG_HOURS, hk);
        repeat (40) @(posedge mclk_in);
        rchk(`REG_HOURS, hk, "hours_frozen");
        wr_reg(`REG_CTRL, 32'h5);
        wait_due(1'b0);
        pins <= 3'h1;
        wait_due(1'b1);
        pins <= 3'h0;
        wr_reg(`REG_CTRL, 32'h4);
        repeat (8) @(posedge mclk_in);
        wait_due(1'b1);
        rd_reg(`REG_IRQ_STAT, v);
        rd_reg(`REG_HOURS, hk);
        pins <= 3'h2;
        wait_due(1'b0);
        rchk(`REG_TIME_LEFT, tv(17'h0, 6'h03), "left_kick");
        rchk(`REG_HOURS, hk, "hours_kick");
        check("irq_masked", {31'h0, irq_out}, 32'h0);
        pins <= 3'h3;
        repeat (80) @(posedge mclk_in);
        check("due_kick_held", {31'h0, due_out}, 32'h0);
        rd_reg(`REG_HOURS, v);
        check("hours_kick_run", {31'h0, v !== hk}, 32'h1);
        pins <= 3'h1;
        wait_due(1'b1);
        pins <= 3'h4;
        wait_due(1'b0);
        pins <= 3'h0;
        repeat (6) @(posedge mclk_in);
        rchk(`REG_HOURS, 32'h0, "hours_wipe");
        rchk(`REG_TIME_LEFT, tv(17'h0, 6'h03), "left_wipe");
        rd_reg(`REG_IRQ_STAT, v);
        check("irq_kick_wipe", v & 32'h6, 32'h6);
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_HOURS_PRESET, tv(17'h0, 6'h3b));
        wr_reg(`REG_CTRL, 32'h4);
        pins <= 3'h1;
        poll_hours(tv(17'h0, 6'h3b), v);
        pins <= 3'h0;
        check("hours_roll", v, tv(17'h1, 6'h00));
        repeat (6) @(posedge mclk_in);
        wr_reg(`REG_HOURS_PRESET, tv(17'h5, 6'h00));
        rchk(`REG_HOURS, tv(17'h1, 6'h00), "preset_run");
        wr_reg(`REG_CTRL, 32'h0);
        wr_reg(`REG_HOURS_PRESET, 32'h0001ffff);
        rchk(`REG_HOURS, tv(17'h1869f, 6'h00), "hours_clamp");
        wr_reg(`REG_CTRL, 32'h4);
        pins <= 3'h1;
        repeat (40) @(posedge mclk_in);
        pins <= 3'h0;
        repeat (6) @(posedge mclk_in);
        rchk(`REG_HOURS, tv(17'h1869f, 6'h00), "hours_sat");
        rd_reg(`REG_STATUS, v);
        check("sat_flag", v & 32'h4, 32'h4);
        wr_reg(`REG_CTRL, 32'h6);
        espan <= 16'h4e20;
        repeat (4) @(posedge mclk_in);
        rchk(`REG_SPAN, tv(17'h0270f, 6'h00), "span_live_clamp");
        espan <= 16'h0007;
        repeat (4) @(posedge mclk_in);
        rchk(`REG_SPAN, tv(17'h7, 6'h00), "span_live");
        rchk(`REG_TIME_LEFT, tv(17'h7, 6'h00), "left_live");
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rchk(`REG_HOURS, tv(17'h1869f, 6'h00), "hours_kept");
        final_report();
    end
endmodule : tb_top
